// *** asf_pkg.sv ***
// shared constants, control register map and saturation helper for the audio filter path
package asf_pkg;
  localparam int DW       = 20;
  localparam int ACC_W    = 39;
  localparam int CW       = 18;
  localparam int FRAC     = 17;
  localparam int PW       = 16;
  localparam int SAT_W    = 41;
  localparam int CNT_W    = 14;
  localparam int HB1_TAPS = 119;
  localparam int HB2_TAPS = 19;
  localparam int HB3_TAPS = 11;
  localparam int DC_SHIFT = 13;
  localparam int COEF_NUM = 83443;
  localparam int CTRL_DM   = 0;
  localparam int CTRL_DCON = 2;
  localparam int CTRL_DC_FILTER_SAMPLE_HOLD = 3;
  localparam logic [CNT_W-1:0] SIL_CNT  = 14'h2274;
  localparam logic [7:0]       REG_CTRL = 8'h00;
  localparam logic [7:0]       REG_PEAK = 8'h04;
  localparam logic [7:0]       REG_STAT = 8'h08;
  localparam logic [3:0]       CTRL_RST = 4'h0;
  localparam logic [1:0]       DM_OFF   = 2'h0;
  localparam logic [1:0]       DM_32    = 2'h1;
  localparam logic [1:0]       DM_441   = 2'h2;
  localparam logic [1:0]       DM_48    = 2'h3;
  localparam logic [15:0]      DM_K32   = 16'h5000;
  localparam logic [15:0]      DM_K441  = 16'h5800;
  localparam logic [15:0]      DM_K48   = 16'h5a00;
  localparam logic [PW-1:0]    PEAK_MAX = 16'h7fff;

  function automatic logic [DW-1:0] sat_dw(input logic signed [SAT_W-1:0] v);
    logic signed [SAT_W-1:0] hi;
    logic signed [SAT_W-1:0] lo;
    hi = SAT_W'((1 << (DW - 1)) - 1);
    lo = ~hi;
    if (v > hi) return hi[DW-1:0];
    if (v < lo) return lo[DW-1:0];
    return v[DW-1:0];
  endfunction
endpackage

// *** asf_audio_path.sv ***
// stereo silence detect, de-emphasis, half-band interpolator, dc filter and peak path
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps

module asf_halfband #(
  parameter int TAPS = asf_pkg::HB1_TAPS
) (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   valid_in,
  input  wire logic [asf_pkg::DW-1:0] data_in,
  output logic                        valid_out,
  output logic                        even_out,
  output logic [asf_pkg::DW-1:0]      data_out
);
  import asf_pkg::*;
  localparam int K  = (TAPS + 1) / 4;
  localparam int IW = $clog2(K + 1);
  localparam int KD = K;

  if ((TAPS % 4 != 3) || (TAPS < 7)) begin : g_bad
    $error("half-band tap count must be 4k-1 and at least 7");
  end

  typedef struct packed {
    logic [2*K-1:0][DW-1:0]  line;
    logic [DW-1:0]           pd;
    logic                    pv;
    logic                    busy;
    logic [IW-1:0]           idx;
    logic signed [ACC_W-1:0] acc;
    logic [FRAC-1:0]         err;
    logic                    pe;
    logic                    vld;
    logic                    even;
    logic [DW-1:0]           dat;
    logic [DW-1:0]           mid;
  } asf_hb_s;

  asf_hb_s s_q;
  asf_hb_s s_d;

  // windowed ideal half-band taps, unity gain at 2^FRAC
  function automatic int coef(input int j);
    int m;
    m = (COEF_NUM / (2 * j + 1)) * (K - j) / K;
    return (j % 2 == 0) ? m : -m;
  endfunction

  logic signed [CW-1:0] ctab [K];
  for (genvar j = 0; j < K; j++) begin : g_coef
    assign ctab[j] = CW'(coef(j));
  end

  always_comb begin
    logic signed [DW:0]    pr;
    logic signed [ACC_W:0] v;
    logic                  go;
    logic [DW-1:0]         src;
    logic [DW-1:0]         ta;
    logic [DW-1:0]         tb;
    pr = '0;
    v = '0;
    ta = '0;
    tb = '0;
    go = (!s_q.busy || (s_q.idx == IW'(K - 1))) && (valid_in || s_q.pv);
    src = s_q.pv ? s_q.pd : data_in;
    s_d = s_q;
    s_d.vld = 1'b0;
    s_d.even = 1'b0;
    // base-rate sample follows the interpolated one, so time order holds
    if (s_q.pe) begin
      s_d.vld = 1'b1;
      s_d.even = 1'b1;
      s_d.dat = s_q.mid;
      s_d.pe = 1'b0;
    end
    if (s_q.busy) begin
      ta = s_q.line[K-1-int'(s_q.idx)];
      tb = s_q.line[K+int'(s_q.idx)];
      pr = $signed({ta[DW-1], ta}) + $signed({tb[DW-1], tb});
      s_d.acc = s_q.acc + ACC_W'(pr) * ACC_W'(ctab[s_q.idx]);
      s_d.idx = s_q.idx + 1'b1;
      if (s_q.idx == IW'(K - 1)) begin
        // first-order error feedback pushes rounding noise out of band
        v = (ACC_W+1)'(s_d.acc) + (ACC_W+1)'($signed({1'b0, s_q.err}));
        s_d.err = v[FRAC-1:0];
        s_d.dat = sat_dw(SAT_W'(v >>> FRAC));
        s_d.mid = s_q.line[K-1];
        s_d.vld = 1'b1;
        s_d.busy = 1'b0;
        s_d.pe = 1'b1;
      end
    end
    // one-deep hold lets the back-to-back pair from the stage before wait;
    // restarting on the last product edge keeps a short stage ahead of pair bursts
    if (go) begin
      s_d.line = {s_q.line[2*K-2:0], src};
      s_d.busy = 1'b1;
      s_d.idx = '0;
      s_d.acc = '0;
      s_d.pv = s_q.pv && valid_in;
      s_d.pd = data_in;
    end else if (valid_in) begin
      s_d.pv = 1'b1;
      s_d.pd = data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign valid_out = s_q.vld;
  assign even_out  = s_q.even;
  assign data_out  = s_q.dat;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_hb_timing;
    valid_in && !s_q.busy && !s_q.pv |=> ##KD valid_out ##1 (valid_out && even_out);
  endproperty
  a_hb_timing: assert property (p_hb_timing)
    else $error("half-band output pair mistimed");
endmodule // asf_halfband

module asf_audio_path #(
  parameter logic [asf_pkg::CNT_W-1:0] SIL_SAMPLES = asf_pkg::SIL_CNT
) (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [7:0]             paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic [31:0]                 prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  input  wire logic                   sample_valid_in,
  input  wire logic [asf_pkg::DW-1:0] left_in,
  input  wire logic [asf_pkg::DW-1:0] right_in,
  output logic                        silence_flag_left_n_out,
  output logic                        silence_flag_right_n_out,
  output logic                        out_valid_out,
  output logic [asf_pkg::DW-1:0]      out_left_out,
  output logic [asf_pkg::DW-1:0]      out_right_out
);
  import asf_pkg::*;
  localparam int LW = DW + DC_SHIFT;

  if (SIL_SAMPLES == '0) begin : g_bad
    $error("silence length must be at least one sample");
  end

  typedef struct packed {
    logic [3:0]            ctrl;
    logic [1:0][CNT_W-1:0] zcnt;
    logic [1:0]            sil_n;
    logic                  dmv;
    logic [1:0][DW-1:0]    dm;
    logic                  dcv;
    logic                  dce;
    logic [1:0][DW-1:0]    dc;
    logic [1:0][LW-1:0]    lp;
    logic [1:0][PW-1:0]    peak;
    logic [31:0]           rdata;
    logic                  err;
  } asf_top_s;

  asf_top_s           s_q;
  asf_top_s           s_d;
  logic [1:0]         hb1_v;
  logic [1:0]         hb1_e;
  logic [1:0]         hb2_v;
  logic [1:0]         hb3_v;
  logic [1:0][DW-1:0] hb1_d;
  logic [1:0][DW-1:0] hb2_d;
  logic [1:0][DW-1:0] hb3_d;
  logic [1:0][PW-1:0] pk_abs;
  logic               setup;
  logic               hit_c;
  logic               hit_p;
  logic               hit_s;
  logic               pk_ev;
  logic               pk_clr;

  // top 16 of 20 bits; the most negative input would wrap, so it is capped
  function automatic logic [PW-1:0] mag(input logic [DW-1:0] x);
    logic [DW-1:0] a;
    a = x[DW-1] ? (~x + 1'b1) : x;
    return (a[DW-1:DW-PW] > PEAK_MAX) ? PEAK_MAX : a[DW-1:DW-PW];
  endfunction

  for (genvar c = 0; c < 2; c++) begin : g_ch
    asf_halfband #(.TAPS(HB1_TAPS)) u_hb1 (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .valid_in  (s_q.dmv),
      .data_in   (s_q.dm[c]),
      .valid_out (hb1_v[c]),
      .even_out  (hb1_e[c]),
      .data_out  (hb1_d[c])
    );
    // dc filter sits here, in the twice-rate domain; the peak here takes only the base-rate samples
    asf_halfband #(.TAPS(HB2_TAPS)) u_hb2 (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .valid_in  (s_q.dcv),
      .data_in   (s_q.dc[c]),
      .valid_out (hb2_v[c]),
      .even_out  (),
      .data_out  (hb2_d[c])
    );
    asf_halfband #(.TAPS(HB3_TAPS)) u_hb3 (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .valid_in  (hb2_v[c]),
      .data_in   (hb2_d[c]),
      .valid_out (hb3_v[c]),
      .even_out  (),
      .data_out  (hb3_d[c])
    );
    assign pk_abs[c] = mag(s_q.dc[c]);
  end

  assign setup  = psel_in && !penable_in;
  assign hit_c  = paddr_in == REG_CTRL;
  assign hit_p  = paddr_in == REG_PEAK;
  assign hit_s  = paddr_in == REG_STAT;
  assign pk_ev  = s_q.dcv && s_q.dce;
  assign pk_clr = setup && !pwrite_in && hit_p;

  always_comb begin
    logic [DW-1:0]      x;
    logic signed [DW:0] dif;
    logic signed [DW+17:0] prod;
    logic [15:0]        k;
    logic signed [LW:0] lpn;
    x = '0;
    dif = '0;
    prod = '0;
    lpn = '0;
    k = '0;
    s_d = s_q;
    s_d.dmv = sample_valid_in;
    s_d.dcv = &hb1_v;
    s_d.dce = &hb1_e;
    // a zero pole gain makes the off setting an exact pass-through
    case (s_q.ctrl[CTRL_DM +: 2])
      DM_32:   k = DM_K32;
      DM_441:  k = DM_K441;
      DM_48:   k = DM_K48;
      default: k = '0;
    endcase
    for (int c = 0; c < 2; c++) begin
      x = (c == 0) ? left_in : right_in;
      if (sample_valid_in) begin
        if (x != '0) begin
          s_d.zcnt[c] = '0;
        end else if (s_q.zcnt[c] != SIL_SAMPLES) begin
          s_d.zcnt[c] = s_q.zcnt[c] + 1'b1;
        end
        dif = $signed({s_q.dm[c][DW-1], s_q.dm[c]}) - $signed({x[DW-1], x});
        prod = dif * $signed({1'b0, k});
        s_d.dm[c] = sat_dw(SAT_W'($signed({x[DW-1], x})) + SAT_W'(prod >>> 16));
      end
      s_d.sil_n[c] = s_d.zcnt[c] != SIL_SAMPLES;
      if (&hb1_v) begin
        s_d.dc[c] = sat_dw(SAT_W'($signed(hb1_d[c]))
                  - SAT_W'($signed(s_q.lp[c][LW-1:DC_SHIFT])));
        // hold trades adaptation for a subtraction value that cannot drift
        if (!s_q.ctrl[CTRL_DC_FILTER_SAMPLE_HOLD]) begin
          lpn = (LW+1)'($signed(s_q.lp[c])) - ((LW+1)'($signed(s_q.lp[c])) >>> DC_SHIFT);
          if (s_q.ctrl[CTRL_DCON]) begin
            lpn = lpn + (LW+1)'($signed(hb1_d[c]));
          end
          s_d.lp[c] = lpn[LW-1:0];
        end
      end
      if (pk_clr) begin
        s_d.peak[c] = pk_ev ? pk_abs[c] : '0;
      end else if (pk_ev && (pk_abs[c] > s_q.peak[c])) begin
        s_d.peak[c] = pk_abs[c];
      end
    end
    if (setup) begin
      s_d.err = !(hit_c || hit_p || hit_s);
      s_d.rdata = '0;
      if (!pwrite_in && hit_c) begin
        s_d.rdata = {28'h0, s_q.ctrl};
      end
      if (!pwrite_in && hit_p) begin
        s_d.rdata = {s_q.peak[1], s_q.peak[0]};
      end
      if (!pwrite_in && hit_s) begin
        s_d.rdata = {30'h0, ~s_q.sil_n};
      end
    end
    if (psel_in && penable_in && pwrite_in && hit_c) begin
      s_d.ctrl = pwdata_in[3:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.sil_n <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  // the audio itself never passes through the silence logic
  assign silence_flag_left_n_out  = s_q.sil_n[0];
  assign silence_flag_right_n_out = s_q.sil_n[1];
  assign prdata_out    = s_q.rdata;
  assign pready_out    = 1'b1;
  assign pslverr_out   = s_q.err;
  assign out_valid_out = &hb3_v;
  assign out_left_out  = hb3_d[0];
  assign out_right_out = hb3_d[1];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_sil_low;
    !silence_flag_left_n_out |-> s_q.zcnt[0] == SIL_SAMPLES;
  endproperty
  a_sil_low: assert property (p_sil_low)
    else $error("silence flag low before full count");

  property p_sil_rel;
    sample_valid_in && (left_in != '0) |=> silence_flag_left_n_out && (s_q.zcnt[0] == '0);
  endproperty
  a_sil_rel: assert property (p_sil_rel)
    else $error("nonzero sample did not release silence flag");

  property p_sil_sep;
    sample_valid_in && (left_in == '0) && (right_in != '0) && !silence_flag_left_n_out
      |=> !silence_flag_left_n_out && silence_flag_right_n_out;
  endproperty
  a_sil_sep: assert property (p_sil_sep)
    else $error("channel silence flags not independent");

  property p_dm_pass;
    sample_valid_in && (s_q.ctrl[CTRL_DM +: 2] == DM_OFF) |=> s_q.dmv && (s_q.dm[0] == $past(left_in));
  endproperty
  a_dm_pass: assert property (p_dm_pass)
    else $error("bypassed de-emphasis altered the sample");

  property p_dc_hold;
    s_q.ctrl[CTRL_DC_FILTER_SAMPLE_HOLD] && $past(s_q.ctrl[CTRL_DC_FILTER_SAMPLE_HOLD]) |-> $stable(s_q.lp);
  endproperty
  a_dc_hold: assert property (p_dc_hold)
    else $error("dc subtraction value moved during hold");

  property p_pk_clr;
    pk_clr && !pk_ev |=> s_q.peak == '0;
  endproperty
  a_pk_clr: assert property (p_pk_clr)
    else $error("peak not cleared by read");

  property p_pk_keep;
    pk_clr && pk_ev |=> s_q.peak[0] == $past(pk_abs[0]);
  endproperty
  a_pk_keep: assert property (p_pk_keep)
    else $error("sample during peak clear was lost");

  property p_pk_max;
    !pk_clr && pk_ev |=> (s_q.peak[0] >= $past(pk_abs[0])) && (s_q.peak[1] >= $past(pk_abs[1]));
  endproperty
  a_pk_max: assert property (p_pk_max)
    else $error("larger sample did not update peak");

  property p_pk_rate;
    !pk_ev && !pk_clr |=> $stable(s_q.peak);
  endproperty
  a_pk_rate: assert property (p_pk_rate)
    else $error("peak changed off the base-rate sample");
endmodule // asf_audio_path

// *** asf_src_model.sv ***
// upstream concealment stage model: paced stereo sample source
`timescale 1ns/1ps
module asf_src_model #(
  parameter int GAP = 48
) (
  input  wire logic                   clk_in,
  output logic                        valid_out,
  output logic [asf_pkg::DW-1:0]      left_out,
  output logic [asf_pkg::DW-1:0]      right_out
);
  import asf_pkg::*;
  initial begin
    valid_out = 1'b0;
    left_out  = '0;
    right_out = '0;
  end
  // gap stays above the 28-cycle minimum, a faster pace would silently drop samples
  task automatic send(input logic [DW-1:0] l, input logic [DW-1:0] r);
    @(posedge clk_in);
    valid_out <= 1'b1;
    left_out  <= l;
    right_out <= r;
    @(posedge clk_in);
    valid_out <= 1'b0;
    // lines no longer show the sample once the strobe is gone
    left_out  <= ~l;
    right_out <= ~r;
    repeat (GAP) @(posedge clk_in);
  endtask
endmodule // asf_src_model

// *** asf_audio_path_tb.sv ***
// self-checking bench for the audio filter path: registers, silence, peaks, rate
`timescale 1ns/1ps
module asf_audio_path_tb;
  import asf_pkg::*;
  logic          clk_in;
  logic          reset_in;
  logic          psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic          sv, sl, sr, ov;
  logic [DW-1:0] l, r, ol, orr;
  int            n_mismatch, cmp_count, n_out;

  asf_src_model src (.clk_in(clk_in), .valid_out(sv), .left_out(l), .right_out(r));
  asf_audio_path #(.SIL_SAMPLES(14'h0004)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .sample_valid_in(sv), .left_in(l),
    .right_in(r), .silence_flag_left_n_out(sl), .silence_flag_right_n_out(sr),
    .out_valid_out(ov), .out_left_out(ol), .out_right_out(orr));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (reset_in === 1'b0 && ov === 1'b1) n_out <= n_out + 1;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held unchanged until pready is sampled high at the access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    reset_in = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_out = 0;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk("flags_rst", 32'({sl, sr}), 32'h3);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_rst", rd, 32'h0);
    apb(1'b0, REG_PEAK, 32'h0);
    chk("peak_rst", rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, REG_CTRL, 32'hffffffff);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_bits", rd, 32'h0000000f);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, REG_CTRL, 32'(m));
      apb(1'b0, REG_CTRL, 32'h0);
      chk("dm_select", rd, 32'(m));
    end
    apb(1'b1, REG_CTRL, 32'h0);
    // right keeps a tiny nonzero value so only the left channel goes silent
    repeat (3) src.send(20'h0, 20'h1);
    chk("flags_3z", 32'({sl, sr}), 32'h3);
    src.send(20'h0, 20'h1);
    chk("flags_4z", 32'({sl, sr}), 32'h1);
    // left stays silent while the right channel holds its nonzero value
    src.send(20'h0, 20'h1);
    chk("flags_5z", 32'({sl, sr}), 32'h1);
    apb(1'b0, REG_STAT, 32'h0);
    chk("stat_sil", rd, 32'h1);
    src.send(20'h1, 20'h0);
    chk("flags_nz", 32'({sl, sr}), 32'h3);
    apb(1'b0, REG_PEAK, 32'h0);
    // full-scale left already gives PEAK_MAX on the base-rate samples, so the cap is reached
    repeat (40) src.send(20'h7ffff, 20'he0000);
    repeat (100) @(posedge clk_in);
    apb(1'b0, REG_PEAK, 32'h0);
    chk("peak_l", 32'(rd[15:0] >= 16'h7800 && rd[15:0] <= PEAK_MAX), 32'h1);
    chk("peak_r", 32'(rd[31:16] >= 16'h1e00 && rd[31:16] <= 16'h2600), 32'h1);
    apb(1'b0, REG_PEAK, 32'h0);
    chk("peak_clr", rd, 32'h0);
    // read setup lands on the edge that takes the base-rate peak sample
    fork
      src.send(20'h7ffff, 20'he0000);
      begin
        repeat (34) @(posedge clk_in);
        apb(1'b0, REG_PEAK, 32'h0);
      end
    join
    chk("peak_race", rd, 32'h0);
    apb(1'b0, REG_PEAK, 32'h0);
    chk("peak_kept", rd, 32'h20007fff);
    repeat (200) @(posedge clk_in);
    chk("out_count", 32'(n_out), 32'(8 * 47));
    chk("out_sign", 32'({ol[DW-1], orr[DW-1], ol == '0}), 32'h2);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    summarize();
  end
endmodule // asf_audio_path_tb
